/* design/wwd_pkg.sv */
// Purpose : Shared constants and types for the windowed watchdog timer.
// Assumes : 8-bit register data, 100 MHz system clock, 1 kHz count clock.
// Notes   : Every offset, field position, reset value and count lives here.

`default_nettype none

package wwd_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam int           ADDR_W       = 8;
   localparam int           DATA_W       = 8;
   localparam logic [7:0]   CTRL_OFS     = 8'h00;  // watchdog_control_reg
   localparam logic [7:0]   STATUS_OFS   = 8'h01;  // Lock and sync pending
   localparam int           PERIOD_LSB   = 0;      // Open span / timeout code
   localparam int           WINDOW_LSB   = 4;      // Closed span code
   localparam int           LOCK_BIT     = 7;
   localparam int           BUSY_BIT     = 0;
   localparam logic [7:0]   CTRL_RST     = 8'h00;
   localparam logic [3:0]   CODE_OFF     = 4'h0;
   localparam logic [3:0]   CODE_MIN     = 4'h1;
   localparam logic [3:0]   CODE_MAX     = 4'hB;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int           SYS_CLK_HZ     = 100_000_000;
   localparam int           SLOW_CLK_HZ    = 1000;
   localparam int           SPAN_MIN_MS    = 8;
   // Shortest span in count-clock ticks, doubled per code step
   localparam int           SPAN_MIN_TICKS = (SPAN_MIN_MS * SLOW_CLK_HZ) / 1000;
   localparam int           CNT_W          = 14;   // Holds the 8K-tick span
   localparam logic [1:0]   SYNC_TICKS     = 2'h2; // Count-clock edges per crossing

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      WWD_OFF    = 4'b0001,
      WWD_WAIT   = 4'b0010,   // Timeout running, closed span not yet armed
      WWD_CLOSED = 4'b0100,
      WWD_OPEN   = 4'b1000
   } wwd_state_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } wwd_bus_req_t;

endpackage : wwd_pkg

`default_nettype wire

/* design/wwd_tick_gen.sv */
// Purpose : Brings the free slow count clock into the system domain as ticks.
// Assumes : The slow clock is far slower than the system clock.
// Notes   : One-cycle tick per rising edge of the slow clock.

`timescale 1ns/1ps
`default_nettype none

module wwd_tick_gen (
   input  wire logic clk_sys_i,
   input  wire logic rst_i,
   input  wire logic slow_count_clock_i,
   output logic      tick_o
);
   import wwd_pkg::*;

   typedef struct packed {
      logic meta;    // First stage, read only by the second
      logic sync;
      logic prev;
      logic tick;
   } wwd_tick_st_t;

   wwd_tick_st_t q;
   wwd_tick_st_t next_q;

   // ----------------------------------------------------------------
   // Synchroniser and edge detect
   // ----------------------------------------------------------------
   // Edge is taken from the second stage so metastability never reaches logic
   always_comb begin
      next_q      = q;
      next_q.meta = slow_count_clock_i;
      next_q.sync = q.meta;
      next_q.prev = q.sync;
      next_q.tick = q.sync & ~q.prev;
   end

   // State register
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign tick_o = q.tick;

endmodule : wwd_tick_gen

`default_nettype wire

/* design/wwd_watchdog.sv */
// Purpose : Windowed watchdog timer with guarded control and freeze bit.
// Assumes : Count clock arrives as a pin and is turned into system ticks.
// Notes   : Count clock crossings are modelled as a wait of two ticks.
//
// Design decisions made here: the plain strobed port and the address map.

`timescale 1ns/1ps
`default_nettype none

module wwd_watchdog (
   input  wire logic                  clk_sys_i,
   input  wire logic                  rst_i,
   input  wire logic                  slow_count_clock_i,
   input  wire wwd_pkg::wwd_bus_req_t bus_i,
   output logic [wwd_pkg::DATA_W-1:0] rdata_o,
   input  wire logic                  change_guard_i,
   input  wire logic [7:0]            boot_config_fuse_i,
   input  wire logic                  debug_halt_i,
   input  wire logic                  watchdog_clear_instruction_i,
   output logic                       domain_sync_pending_o,
   output logic                       rst_req_o
);
   import wwd_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0]       ctrl;      // Software view of the control register
      logic [7:0]       ctrl_eff;  // Copy in force in the counting domain
      logic             lock;
      logic             sync_busy;
      logic [1:0]       sync_cnt;
      logic             clr_busy;
      logic [1:0]       clr_cnt;
      wwd_state_t       state;
      logic [CNT_W-1:0] cnt;
      logic             rst_req;
      logic [7:0]       rdata;
      logic             booted;
      logic             halted;
   } wwd_st_t;

   wwd_st_t q;
   wwd_st_t next_q;
   logic    tick;
   logic    apply_cfg;
   logic    apply_clr;
   logic    wr_ctrl_ok;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Span in ticks for a code; reserved codes run the longest span
   function automatic logic [CNT_W:0] span_of(input logic [3:0] code);
      logic [CNT_W:0] s;
      s = (CNT_W+1)'(SPAN_MIN_TICKS);
      if (code >= CODE_MIN && code <= CODE_MAX) begin
         s = s << (code - CODE_MIN);
      end else begin
         s = s << (CODE_MAX - CODE_MIN);
      end
      return s;
   endfunction : span_of

   // State a configuration starts in
   function automatic wwd_state_t entry_of(input logic [7:0] c);
      wwd_state_t e;
      if (c[PERIOD_LSB +: 4] == CODE_OFF) begin
         e = WWD_OFF;
      end else if (c[WINDOW_LSB +: 4] != CODE_OFF) begin
         e = WWD_WAIT;
      end else begin
         e = WWD_OPEN;
      end
      return e;
   endfunction : entry_of

   // True when the next tick completes the given span
   function automatic logic expires(input logic [CNT_W-1:0] c, input logic [3:0] code);
      return ({1'b0, c} + (CNT_W+1)'(1)) >= span_of(code);
   endfunction : expires

   // ----------------------------------------------------------------
   // Count clock ticks
   // ----------------------------------------------------------------
   // The count clock is a free 1 kHz pin; only its edges pace the counter
   wwd_tick_gen u_tick (
      .clk_sys_i          (clk_sys_i),
      .rst_i              (rst_i),
      .slow_count_clock_i (slow_count_clock_i),
      .tick_o             (tick)
   );

   // Crossing completions, taken on the second count-clock edge
   assign apply_cfg  = tick & q.sync_busy & (q.sync_cnt == 2'h1);
   assign apply_clr  = tick & q.clr_busy & (q.clr_cnt == 2'h1);
   assign wr_ctrl_ok = bus_i.wr & (bus_i.addr == CTRL_OFS) & change_guard_i
                       & ~q.lock & ~q.sync_busy;

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      next_q         = q;
      next_q.rst_req = 1'b0;
      next_q.rdata   = 8'h00;

      // Register reads, data in the following cycle
      if (bus_i.rd) begin
         if (bus_i.addr == CTRL_OFS) begin
            next_q.rdata = q.ctrl;
         end else if (bus_i.addr == STATUS_OFS) begin
            next_q.rdata[LOCK_BIT] = q.lock;
            next_q.rdata[BUSY_BIT] = q.sync_busy;
         end
      end

      // Control write starts a crossing; ignored while guarded or frozen
      if (wr_ctrl_ok) begin
         next_q.ctrl      = bus_i.wdata;
         next_q.sync_busy = 1'b1;
         next_q.sync_cnt  = SYNC_TICKS;
      end

      // Freeze bit: set by software, cleared only while halted in debug
      if (bus_i.wr && bus_i.addr == STATUS_OFS && change_guard_i) begin
         if (bus_i.wdata[LOCK_BIT]) begin
            next_q.lock = 1'b1;
         end else if (debug_halt_i) begin
            next_q.lock = 1'b0;
         end
      end

      // Clear instruction crossing; a second one inside it is dropped
      if (watchdog_clear_instruction_i && !q.clr_busy) begin
         next_q.clr_busy = 1'b1;
         next_q.clr_cnt  = SYNC_TICKS;
      end

      // Crossing progress on count-clock edges
      if (tick && q.sync_busy) begin
         next_q.sync_cnt = q.sync_cnt - 2'h1;
         if (apply_cfg) begin
            next_q.sync_busy = 1'b0;
         end
      end
      if (tick && q.clr_busy) begin
         next_q.clr_cnt = q.clr_cnt - 2'h1;
         if (apply_clr) begin
            next_q.clr_busy = 1'b0;
         end
      end

      // Counting; no sleep or clock-stop input can pause it
      if (debug_halt_i) begin
         next_q.halted = 1'b1;
         next_q.cnt    = '0;
      end else if (q.halted) begin
         // Leaving debug halt re-arms the closed span behind a clear
         next_q.halted = 1'b0;
         next_q.state  = entry_of(q.ctrl_eff);
         next_q.cnt    = '0;
      end else if (tick) begin
         unique case (q.state)
            WWD_OFF: begin
               next_q.cnt = '0;
            end
            WWD_WAIT,
            WWD_OPEN: begin
               if (apply_clr) begin
                  next_q.cnt = '0;
                  if (q.ctrl_eff[WINDOW_LSB +: 4] != CODE_OFF) begin
                     next_q.state = WWD_CLOSED;
                  end else begin
                     next_q.state = WWD_OPEN;
                  end
               end else if (expires(q.cnt, q.ctrl_eff[PERIOD_LSB +: 4])) begin
                  next_q.rst_req = 1'b1;
                  next_q.cnt     = '0;
                  next_q.state   = entry_of(q.ctrl_eff);
               end else begin
                  next_q.cnt = q.cnt + CNT_W'(1);
               end
            end
            WWD_CLOSED: begin
               if (apply_clr) begin
                  next_q.rst_req = 1'b1;
                  next_q.cnt     = '0;
                  next_q.state   = entry_of(q.ctrl_eff);
               end else if (expires(q.cnt, q.ctrl_eff[WINDOW_LSB +: 4])) begin
                  next_q.state = WWD_OPEN;
                  next_q.cnt   = '0;
               end else begin
                  next_q.cnt = q.cnt + CNT_W'(1);
               end
            end
         endcase
      end

      // New configuration lands in the counting domain
      if (apply_cfg) begin
         next_q.ctrl_eff = q.ctrl;
         if (entry_of(q.ctrl) != entry_of(q.ctrl_eff)) begin
            next_q.state = entry_of(q.ctrl);
            next_q.cnt   = '0;
         end
      end

      // First cycle after reset release: take the boot fuse
      if (!q.booted) begin
         next_q.booted   = 1'b1;
         next_q.ctrl     = boot_config_fuse_i;
         next_q.ctrl_eff = boot_config_fuse_i;
         next_q.lock     = (boot_config_fuse_i[PERIOD_LSB +: 4] != CODE_OFF);
         next_q.state    = entry_of(boot_config_fuse_i);
         next_q.cnt      = '0;
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   // Reset takes constants only; the fuse is caught after release
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         q          <= '0;
         q.ctrl     <= CTRL_RST;
         q.ctrl_eff <= CTRL_RST;
         q.state    <= WWD_OFF;
      end else begin
         q <= next_q;
      end
   end

   // Outputs straight from flip-flops
   assign rdata_o               = q.rdata;
   assign domain_sync_pending_o = q.sync_busy;
   assign rst_req_o             = q.rst_req;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (rst_i);

   guard_block_a : assert property (
      (q.booted && bus_i.wr && bus_i.addr == CTRL_OFS && !change_guard_i) |=> $stable(q.ctrl))
      else $error("control changed without guard unlock");

   freeze_hold_a : assert property (
      (q.booted && q.lock) |=> $stable(q.ctrl))
      else $error("control changed while frozen");

   boot_freeze_a : assert property (
      (!q.booted && boot_config_fuse_i[PERIOD_LSB +: 4] != CODE_OFF) |=> (q.lock && q.ctrl == $past(boot_config_fuse_i)))
      else $error("enabled fuse did not load and freeze");

   sync_flag_a : assert property (
      wr_ctrl_ok |=> (q.sync_busy && q.sync_cnt == SYNC_TICKS))
      else $error("pending flag not raised on control write");

   closed_clear_a : assert property (
      (tick && apply_clr && q.state == WWD_CLOSED && q.booted && !q.halted && !debug_halt_i)
      |=> rst_req_o ##1 !rst_req_o)
      else $error("clear in closed span did not reset");

   normal_expiry_a : assert property (
      (tick && q.state == WWD_OPEN && !apply_clr && !debug_halt_i && !q.halted && q.booted
       && expires(q.cnt, q.ctrl_eff[PERIOD_LSB +: 4])) |=> (rst_req_o && q.cnt == '0))
      else $error("timeout did not request reset");

   clear_restart_a : assert property (
      (apply_clr && q.state == WWD_OPEN && !debug_halt_i && !q.halted && q.booted && !apply_cfg)
      |=> (q.cnt == '0 && !rst_req_o))
      else $error("accepted clear did not restart count");

   clear_drop_a : assert property (
      (q.clr_busy && !apply_clr && watchdog_clear_instruction_i)
      |=> (q.clr_cnt == $past(q.clr_cnt) - ($past(tick) ? 2'h1 : 2'h0)))
      else $error("clear during crossing restarted crossing");

   off_quiet_a : assert property (
      (q.state == WWD_OFF && q.ctrl_eff[PERIOD_LSB +: 4] == CODE_OFF) |=> !rst_req_o)
      else $error("disabled watchdog requested reset");

   pulse_width_a : assert property (
      rst_req_o |=> !rst_req_o)
      else $error("reset request longer than one cycle");

endmodule : wwd_watchdog

`default_nettype wire

/* sim/wwd_cpu_model.sv */
// Purpose : Behavioural processor core that issues watchdog clear instructions.
// Assumes : Same clock domain as the watchdog; one clear pulse per request.
// Notes   : Each request carries a delay, so clears can come at once or late.

`timescale 1ns/1ps
`default_nettype none

module wwd_cpu_model (
   input  wire logic        clk_sys_i,
   input  wire logic        rst_i,
   input  wire logic        go_i,
   input  wire logic [15:0] wait_i,
   output logic             clear_o,
   output logic             busy_o
);
   logic [15:0] cnt;

   // -------------------------------------------------------------
   // Delay, then one clear pulse
   // -------------------------------------------------------------
   // A new request overrides any pending one, like a core jumping ahead
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         cnt     <= 16'h0000;
         busy_o  <= 1'b0;
         clear_o <= 1'b0;
      end else begin
         clear_o <= 1'b0;
         if (go_i) begin
            busy_o <= 1'b1;
            cnt    <= wait_i;
         end else if (busy_o && cnt != 16'h0000) begin
            cnt <= cnt - 16'h0001;
         end else if (busy_o) begin
            clear_o <= 1'b1;   // Stands for exactly one cycle
            busy_o  <= 1'b0;
         end
      end
   end
endmodule : wwd_cpu_model

`default_nettype wire

/* sim/windowed_watchdog_timer_tb.sv */
// Purpose : Self-checking bench for the windowed watchdog timer.
// Assumes : Count clock runs fast (206 ns) so long spans stay short.
// Notes   : Span timing is judged in system cycles with about a tick of slack.

`timescale 1ns/1ps
`default_nettype none

module windowed_watchdog_timer_tb;
   import wwd_pkg::*;

   localparam int SLOW_HALF = 103;   // Half period of the count clock in ns

   logic         clk_sys_i = 1'b0;
   logic         rst_i     = 1'b1;
   logic         slow      = 1'b0;
   wwd_bus_req_t bus       = '0;
   logic [7:0]   rdata;
   logic         guard     = 1'b0;
   logic [7:0]   fuse      = 8'h00;
   logic         dbg       = 1'b0;
   logic         clr;
   logic         pend;
   logic         rst_req;
   logic         go        = 1'b0;
   logic [15:0]  gap       = 16'h0000;
   logic         busy;
   int           errors    = 0;
   int           compares  = 0;
   int           n_rst     = 0;
   integer       seed      = 32'ha5dd9558;
   logic [7:0]   d;
   int           k;

   // -------------------------------------------------------------
   // Clocks, design and partner
   // -------------------------------------------------------------
   always #5 clk_sys_i = ~clk_sys_i;
   // Count clock has no phase relation to the system clock
   always #(SLOW_HALF) slow = ~slow;

   wwd_watchdog DUT (
      .clk_sys_i                    (clk_sys_i),
      .rst_i                        (rst_i),
      .slow_count_clock_i           (slow),
      .bus_i                        (bus),
      .rdata_o                      (rdata),
      .change_guard_i               (guard),
      .boot_config_fuse_i           (fuse),
      .debug_halt_i                 (dbg),
      .watchdog_clear_instruction_i (clr),
      .domain_sync_pending_o        (pend),
      .rst_req_o                    (rst_req)
   );

   wwd_cpu_model cpu (
      .clk_sys_i (clk_sys_i),
      .rst_i     (rst_i),
      .go_i      (go),
      .wait_i    (gap),
      .clear_o   (clr),
      .busy_o    (busy)
   );

   // Count every reset request pulse
   always @(posedge clk_sys_i) begin
      if (rst_req === 1'b1) n_rst <= n_rst + 1;
   end

   // -------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------
   function automatic int span_cyc(input int c);
      return ((8 << (c - 1)) * 2 * SLOW_HALF) / 10;
   endfunction : span_cyc

   task automatic test_done;
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : test_done

   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      compares++;
      if (g !== e) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk

   task automatic rng(input int g, input int lo, input int hi);
      compares++;
      if (g < lo || g > hi) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h to %h", $time, g, lo, hi);
      end
      if (g > hi) test_done;
   endtask : rng

   task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic g);
      @(posedge clk_sys_i);
      bus.addr  <= a;
      bus.wdata <= v;
      bus.wr    <= 1'b1;
      guard     <= g;
      @(posedge clk_sys_i);
      bus.wr    <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk_sys_i);
      bus.addr <= a;
      bus.rd   <= 1'b1;
      @(posedge clk_sys_i);
      bus.rd   <= 1'b0;
      #1 v = rdata;
   endtask : rd

   // Guarded write, refused second write while crossing, wait for apply
   task automatic wr_sync(input logic [7:0] v);
      int n;
      n = 0;
      wr(CTRL_OFS, v, 1'b1);
      #1 chk(pend, 1'b1);
      wr(CTRL_OFS, 8'h0B, 1'b1);
      rd(CTRL_OFS, d);
      chk(d, v);
      while (pend !== 1'b0 && n < 300) begin
         @(posedge clk_sys_i);
         #1 n++;
      end
      rng(n, 1, 299);
   endtask : wr_sync

   // Cycles until the next reset request must fall in lo..hi
   task automatic wait_rst(input int lo, input int hi);
      int n;
      n = 0;
      do begin
         @(posedge clk_sys_i);
         #1 n++;
      end while (rst_req !== 1'b1 && n <= hi);
      rng(n, lo, hi);
   endtask : wait_rst

   task automatic quiet(input int c);
      int b;
      b = n_rst;
      repeat (c) @(posedge clk_sys_i);
      chk(16'(n_rst - b), 16'h0000);
   endtask : quiet

   task automatic clear(input int w);
      int n;
      n = 0;
      @(posedge clk_sys_i);
      go  <= 1'b1;
      gap <= 16'(w);
      @(posedge clk_sys_i);
      go  <= 1'b0;
      do begin
         @(posedge clk_sys_i);
         #1 n++;
      end while (busy !== 1'b0 && n < 2000);
      rng(n, 1, 1999);
   endtask : clear

   task automatic do_reset(input logic [7:0] f);
      @(posedge clk_sys_i);
      fuse  <= f;
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      @(posedge clk_sys_i);
   endtask : do_reset

   // -------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------
   initial begin
      do_reset(8'h00);
      rd(CTRL_OFS, d);
      chk(d, 8'h00);
      rd(STATUS_OFS, d);
      chk(d, 8'h00);
      rd(8'h05, d);
      chk(d, 8'h00);
      wr(CTRL_OFS, 8'h01, 1'b0);
      #1 chk(pend, 1'b0);
      rd(CTRL_OFS, d);
      chk(d, 8'h00);
      quiet(400);
      // Period codes: spacing of successive expiries
      for (int c = 1; c <= 4; c++) begin
         wr_sync(8'(c));
         wait_rst(1, 4000);
         wait_rst(span_cyc(c) - 25, span_cyc(c) + 25);
      end
      // Random clears in time keep normal mode quiet; going through off restarts the count
      wr_sync(8'h00);
      wr_sync(8'h01);
      clear(0);
      k = n_rst;
      repeat (20) clear(70 + ($random(seed) & 31));
      chk(16'(n_rst - k), 16'h0000);
      // Window mode: early clear, dropped clear, late expiry, good clear
      wr_sync(8'h11);
      clear(0);
      clear(80);
      wait_rst(15, 90);
      clear(0);
      clear(0);
      wait_rst(320, 430);
      clear(0);
      clear(240 + ($random(seed) & 15));
      quiet(150);
      // Freeze bit and debug halt
      wr(STATUS_OFS, 8'h80, 1'b1);
      rd(STATUS_OFS, d);
      chk(d, 8'h80);
      wr(STATUS_OFS, 8'h00, 1'b1);
      rd(STATUS_OFS, d);
      chk(d, 8'h80);
      wr(CTRL_OFS, 8'h00, 1'b1);
      #1 chk(pend, 1'b0);
      rd(CTRL_OFS, d);
      chk(d, 8'h11);
      dbg <= 1'b1;
      quiet(600);
      wr(STATUS_OFS, 8'h00, 1'b1);
      rd(STATUS_OFS, d);
      chk(d, 8'h00);
      dbg <= 1'b0;
      wr_sync(8'h00);
      quiet(700);
      // Reset in mid-run with an enabling fuse
      do_reset(8'h21);
      rd(CTRL_OFS, d);
      chk(d, 8'h21);
      rd(STATUS_OFS, d);
      chk(d, 8'h80);
      test_done;
   end
endmodule : windowed_watchdog_timer_tb

`default_nettype wire
